// [logic/dcc_defs.vh]
// Overview of operation
// - Commands 00H, 02H, 03H return revision, status and runtime counter to host.
// - Command 04H writes control register from next byte; 05H reads it back.
// - Under read protection a control write is accepted but keeps the halt flag.
// - Outside halt only commands 00H, 02H, 04H, 05H execute; others need halt.
// - Read protection refuses PC, register read, memory access and step, stuff, execute.
// - Under read protection register write 08H only reaches flash control registers.
// - Under read protection only mass-erase may be written to flash control at FF8H.
// - Command 0EH returns program memory checksum, also under read protection.
// - Revision value identifies command set version and changes with commands.
// - Writing 81H to control resets device and leaves it halted.
// - Writing 41H to control resets device, runs with breakpoints enabled.
// - While halted, writing 40H resumes execution with breakpoints enabled.
// - Setting halt flag bit 7 enters debug state; CPU stops fetching.
// - Clearing halt flag returns to normal state; CPU resumes fetching.
// - Hardware sets halt flag on breakpoint opcode with breakpoints enabled.
// - With read protection, writing 0 cannot clear halt flag; only reset can.
// - Breakpoint enable bit 6 resets disabled; opcode 00H then acts as no-op.
// - Enabled breakpoint opcode acts per breakpoint loop bit 4.
// - With acknowledge enable bit 5 set, FFH is sent on each breakpoint taken while breakpoint enable bit 6 is set.
// - Unit is transmitter, receiver, baud generator and command controller.
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH
`define DCC_CMD_REV 8'h00
`define DCC_CMD_STAT 8'h02
`define DCC_CMD_RTC 8'h03
`define DCC_CMD_WCTL 8'h04
`define DCC_CMD_RCTL 8'h05
`define DCC_CMD_WPC 8'h06
`define DCC_CMD_RPC 8'h07
`define DCC_CMD_WREG 8'h08
`define DCC_CMD_RREG 8'h09
`define DCC_CMD_WPM 8'h0a
`define DCC_CMD_RPM 8'h0b
`define DCC_CMD_WDM 8'h0c
`define DCC_CMD_RDM 8'h0d
`define DCC_CMD_CRC 8'h0e
`define DCC_CMD_STEP 8'h10
`define DCC_CMD_STUFF 8'h11
`define DCC_CMD_EXEC 8'h12
`define DCC_BIT_HALT 7
`define DCC_BIT_BREAKPOINT_ENABLE 6
`define DCC_BIT_ACK 5
`define DCC_BIT_LOOP 4
`define DCC_BIT_RST 0
`define DCC_CTL_RESET 8'h00
`define DCC_CTL_WMASK 8'hf1
`define DCC_ACK_BYTE 8'hff
`define DCC_REVISION 16'h0100
`define DCC_FCTL_LO 12'hff8
`define DCC_FCTL_HI 12'hfff
`define DCC_FCTL_ADDR 12'hff8
`define DCC_MASS_ERASE 8'h63
`define DCC_BAUD_DIV 16'h0040
`endif

// [logic/dcc_uart_rx.v]
`include "dcc_defs.vh"
`default_nettype none
module dcc_uart_rx (
    input wire clk_i,
    input wire rst_n_i,
    input wire [15:0] div_i,
    input wire rx_i,
    output reg [7:0] data_o,
    output reg valid_o
);
    reg [15:0] cnt_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg busy_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            busy_q <= 1'b0;
            data_o <= 8'h00;
            valid_o <= 1'b0;
        end else begin
            valid_o <= 1'b0;
            if (!busy_q) begin
                if (!rx_i) begin
                    busy_q <= 1'b1;
                    cnt_q <= {1'b0, div_i[15:1]};
                    bit_q <= 4'h0;
                end
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end else begin
                cnt_q <= div_i;
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h0 && rx_i) begin
                    busy_q <= 1'b0;
                end else if (bit_q >= 4'h1 && bit_q <= 4'h8) begin
                    sh_q <= {rx_i, sh_q[7:1]};
                end else if (bit_q == 4'h9) begin
                    busy_q <= 1'b0;
                    data_o <= sh_q;
                    valid_o <= rx_i;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [logic/dcc_uart_tx.v]
`include "dcc_defs.vh"
`default_nettype none
module dcc_uart_tx (
    input wire clk_i,
    input wire rst_n_i,
    input wire [15:0] div_i,
    input wire [7:0] data_i,
    input wire start_i,
    output reg tx_o,
    output reg busy_o
);
    reg [15:0] cnt_q;
    reg [3:0] bit_q;
    reg [9:0] sh_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            sh_q <= 10'h3ff;
            tx_o <= 1'b1;
            busy_o <= 1'b0;
        end else if (!busy_o) begin
            tx_o <= 1'b1;
            if (start_i) begin
                busy_o <= 1'b1;
                sh_q <= {1'b1, data_i, 1'b0};
                bit_q <= 4'h0;
                cnt_q <= 16'h0000;
            end
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end else if (bit_q == 4'ha) begin
            busy_o <= 1'b0;
            tx_o <= 1'b1;
        end else begin
            tx_o <= sh_q[0];
            sh_q <= {1'b1, sh_q[9:1]};
            bit_q <= bit_q + 4'h1;
            cnt_q <= div_i;
        end
    end
endmodule
`default_nettype wire

// [logic/dcc_top.v]
`include "dcc_defs.vh"
`default_nettype none
module dcc_top (
    input wire MCLK_I,
    input wire RST_N_I,
    input wire DBG_RX_I,
    output reg DBG_TX_O,
    input wire READ_PROTECT_I,
    input wire BRK_DECODE_I,
    input wire [7:0] STATUS_I,
    input wire [15:0] PC_I,
    input wire [7:0] RD_DATA_I,
    input wire CPU_READY_I,
    input wire [15:0] CRC_I,
    output reg CPU_HALT_O,
    output reg BRK_AS_NOP_O,
    output reg BRK_LOOP_O,
    output reg DEV_RESET_O,
    output reg [7:0] CTRL_O,
    output reg REQ_O,
    output reg [3:0] REQ_KIND_O,
    output reg [15:0] REQ_ADDR_O,
    output reg [7:0] REQ_DATA_O
);
    // ****************************************
    // Serial link
    // ****************************************
    localparam [3:0] K_WPC = 4'h1, K_RPC = 4'h2, K_WREG = 4'h3, K_RREG = 4'h4;
    localparam [3:0] K_WPM = 4'h5, K_RPM = 4'h6, K_WDM = 4'h7, K_RDM = 4'h8;
    localparam [3:0] K_STEP = 4'h9, K_STUFF = 4'ha, K_EXEC = 4'hb;
    localparam [3:0] K_CRC = 4'hc, K_RTC = 4'hd;
    localparam [2:0] S_CMD = 3'd0, S_ARG = 3'd1, S_REQ = 3'd2, S_SEND = 3'd3;
    localparam [2:0] S_WAIT = 3'd4;
    wire [7:0] rx_data;
    wire rx_valid;
    wire tx_line;
    wire tx_busy;
    reg tx_start;
    reg [7:0] tx_byte;
    dcc_uart_rx u_rx (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .div_i(`DCC_BAUD_DIV),
        .rx_i(DBG_RX_I),
        .data_o(rx_data),
        .valid_o(rx_valid)
    );
    dcc_uart_tx u_tx (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .div_i(`DCC_BAUD_DIV),
        .data_i(tx_byte),
        .start_i(tx_start),
        .tx_o(tx_line),
        .busy_o(tx_busy)
    );
    // ****************************************
    // Command decode helpers
    // ****************************************
    function [3:0] cmd_kind;
        input [7:0] c;
        begin
            case (c)
                `DCC_CMD_WPC: cmd_kind = K_WPC;
                `DCC_CMD_RPC: cmd_kind = K_RPC;
                `DCC_CMD_WREG: cmd_kind = K_WREG;
                `DCC_CMD_RREG: cmd_kind = K_RREG;
                `DCC_CMD_WPM: cmd_kind = K_WPM;
                `DCC_CMD_RPM: cmd_kind = K_RPM;
                `DCC_CMD_WDM: cmd_kind = K_WDM;
                `DCC_CMD_RDM: cmd_kind = K_RDM;
                `DCC_CMD_STEP: cmd_kind = K_STEP;
                `DCC_CMD_STUFF: cmd_kind = K_STUFF;
                `DCC_CMD_EXEC: cmd_kind = K_EXEC;
                `DCC_CMD_CRC: cmd_kind = K_CRC;
                `DCC_CMD_RTC: cmd_kind = K_RTC;
                default: cmd_kind = 4'h0;
            endcase
        end
    endfunction
    // Argument bytes: 2 address + 1 data for register/memory writes, 2 address for their reads, 2 for PC write
    function [1:0] arg_count;
        input [3:0] kd;
        begin
            case (kd)
                K_WPC: arg_count = 2'd2;
                K_WREG, K_WPM, K_WDM: arg_count = 2'd3;
                K_RREG, K_RPM, K_RDM: arg_count = 2'd2;
                K_STUFF, K_EXEC: arg_count = 2'd1;
                default: arg_count = 2'd0;
            endcase
        end
    endfunction
    // ****************************************
    // Control register and command FSM
    // ****************************************
    reg [7:0] ctl_q;
    reg [31:0] rtc_q;
    reg [2:0] st_q;
    reg [3:0] kind_q;
    reg [1:0] argn_q;
    reg [23:0] arg_q;
    reg [31:0] out_q;
    reg [2:0] outn_q;
    reg wctl_q;
    reg ack_pend_q;
    reg [7:0] wr;
    reg allowed;
    reg [3:0] k;
    always @* begin
        k = cmd_kind(rx_data);
        allowed = ctl_q[`DCC_BIT_HALT] && k != 4'h0;
        if (READ_PROTECT_I && k != K_CRC && k != K_RTC && k != K_WREG) begin
            allowed = 1'b0;
        end
        wr = rx_data & `DCC_CTL_WMASK;
        if (READ_PROTECT_I && ctl_q[`DCC_BIT_HALT]) begin
            wr[`DCC_BIT_HALT] = 1'b1;
        end
    end
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctl_q <= `DCC_CTL_RESET;
            rtc_q <= 32'h00000000;
            st_q <= S_CMD;
            kind_q <= 4'h0;
            argn_q <= 2'd0;
            arg_q <= 24'h000000;
            out_q <= 32'h00000000;
            outn_q <= 3'd0;
            wctl_q <= 1'b0;
            ack_pend_q <= 1'b0;
            tx_start <= 1'b0;
            tx_byte <= 8'h00;
            REQ_O <= 1'b0;
            REQ_KIND_O <= 4'h0;
            REQ_ADDR_O <= 16'h0000;
            REQ_DATA_O <= 8'h00;
        end else begin
            tx_start <= 1'b0;
            REQ_O <= 1'b0;
            if (!ctl_q[`DCC_BIT_HALT]) begin
                rtc_q <= rtc_q + 32'h00000001;
            end
            if (ctl_q[`DCC_BIT_RST]) begin
                ctl_q[`DCC_BIT_RST] <= 1'b0;
            end
            case (st_q)
                S_CMD: begin
                    if (ack_pend_q && !tx_busy && !tx_start) begin
                        tx_byte <= `DCC_ACK_BYTE;
                        tx_start <= 1'b1;
                        ack_pend_q <= 1'b0;
                    end else if (rx_valid) begin
                        kind_q <= k;
                        arg_q <= 24'h000000;
                        case (rx_data)
                            `DCC_CMD_REV: begin
                                out_q <= {`DCC_REVISION, 16'h0000};
                                outn_q <= 3'd2;
                                st_q <= S_SEND;
                            end
                            `DCC_CMD_STAT: begin
                                out_q <= {STATUS_I, 24'h000000};
                                outn_q <= 3'd1;
                                st_q <= S_SEND;
                            end
                            `DCC_CMD_WCTL: begin
                                wctl_q <= 1'b1;
                                argn_q <= 2'd1;
                                st_q <= S_ARG;
                            end
                            `DCC_CMD_RCTL: begin
                                out_q <= {ctl_q & `DCC_CTL_WMASK, 24'h000000};
                                outn_q <= 3'd1;
                                st_q <= S_SEND;
                            end
                            default: begin
                                if (allowed) begin
                                    wctl_q <= 1'b0;
                                    argn_q <= arg_count(k);
                                    st_q <= (arg_count(k) == 2'd0) ? S_REQ : S_ARG;
                                end
                            end
                        endcase
                    end
                end
                S_ARG: begin
                    if (rx_valid) begin
                        if (wctl_q) begin
                            wctl_q <= 1'b0;
                            st_q <= S_CMD;
                            ctl_q <= wr;
                        end else begin
                            arg_q <= {arg_q[15:0], rx_data};
                            argn_q <= argn_q - 2'd1;
                            if (argn_q == 2'd1) begin
                                st_q <= S_REQ;
                            end
                        end
                    end
                end
                S_REQ: begin
                    st_q <= S_CMD;
                    case (kind_q)
                        K_CRC: begin
                            out_q <= {CRC_I, 16'h0000};
                            outn_q <= 3'd2;
                            st_q <= S_SEND;
                        end
                        K_RTC: begin
                            out_q <= rtc_q;
                            outn_q <= 3'd4;
                            st_q <= S_SEND;
                        end
                        K_RPC: begin
                            out_q <= {PC_I, 16'h0000};
                            outn_q <= 3'd2;
                            st_q <= S_SEND;
                        end
                        K_WREG: begin
                            if (!READ_PROTECT_I || (arg_q[23:20] == 4'h0 &&
                                arg_q[19:8] >= `DCC_FCTL_LO &&
                                arg_q[19:8] <= `DCC_FCTL_HI && (arg_q[19:8] !=
                                `DCC_FCTL_ADDR || arg_q[7:0] == `DCC_MASS_ERASE))) begin
                                REQ_O <= 1'b1;
                            end
                        end
                        default: begin
                            REQ_O <= 1'b1;
                            if (kind_q == K_RREG || kind_q == K_RPM || kind_q == K_RDM) begin
                                st_q <= S_WAIT;
                            end
                        end
                    endcase
                    REQ_KIND_O <= kind_q;
                    REQ_ADDR_O <= (argn_q == 2'd0 && arg_count(kind_q) == 2'd3) ?
                        arg_q[23:8] : arg_q[15:0];
                    REQ_DATA_O <= arg_q[7:0];
                end
                S_WAIT: begin
                    if (CPU_READY_I) begin
                        out_q <= {RD_DATA_I, 24'h000000};
                        outn_q <= 3'd1;
                        st_q <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (outn_q == 3'd0) begin
                        st_q <= S_CMD;
                    end else if (!tx_busy && !tx_start) begin
                        tx_byte <= out_q[31:24];
                        tx_start <= 1'b1;
                        out_q <= {out_q[23:0], 8'h00};
                        outn_q <= outn_q - 3'd1;
                    end
                end
                default: st_q <= S_CMD;
            endcase
            // breakpoint halts CPU, wins over a same-cycle write
            if (BRK_DECODE_I && ctl_q[`DCC_BIT_BREAKPOINT_ENABLE]) begin
                ctl_q[`DCC_BIT_HALT] <= 1'b1;
                ack_pend_q <= ctl_q[`DCC_BIT_ACK];
            end
        end
    end
    // ****************************************
    // Registered outputs
    // ****************************************
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DBG_TX_O <= 1'b1;
            CPU_HALT_O <= 1'b0;
            BRK_AS_NOP_O <= 1'b1;
            BRK_LOOP_O <= 1'b0;
            DEV_RESET_O <= 1'b0;
            CTRL_O <= 8'h00;
        end else begin
            DBG_TX_O <= tx_line;
            CPU_HALT_O <= ctl_q[`DCC_BIT_HALT];
            BRK_AS_NOP_O <= ~ctl_q[`DCC_BIT_BREAKPOINT_ENABLE];
            BRK_LOOP_O <= ctl_q[`DCC_BIT_LOOP];
            DEV_RESET_O <= ctl_q[`DCC_BIT_RST];
            CTRL_O <= ctl_q & `DCC_CTL_WMASK;
        end
    end
endmodule
`default_nettype wire

// [tb/dcc_top_sva.sv]
`include "dcc_defs.vh"
`default_nettype none
module dcc_top_sva (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic READ_PROTECT_I,
    input wire logic BRK_DECODE_I,
    input wire logic CPU_HALT_O,
    input wire logic BRK_AS_NOP_O,
    input wire logic BRK_LOOP_O,
    input wire logic DEV_RESET_O,
    input wire logic [7:0] CTRL_O,
    input wire logic REQ_O,
    input wire logic [3:0] REQ_KIND_O,
    input wire logic [15:0] REQ_ADDR_O,
    input wire logic [7:0] REQ_DATA_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Control checks
    // ****************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence brk_s;
        BRK_DECODE_I && CTRL_O[6] && !CPU_HALT_O;
    endsequence
    sequence rst_done_s;
        !DEV_RESET_O && !CTRL_O[0];
    endsequence
    halt_mirror_a: assert property (CPU_HALT_O == CTRL_O[7])
        else $error("Halt output differs from control bit 7");
    nop_mirror_a: assert property (BRK_AS_NOP_O == !CTRL_O[6])
        else $error("No-op output differs from enable bit");
    loop_mirror_a: assert property (BRK_LOOP_O == CTRL_O[4])
        else $error("Loop output differs from control bit 4");
    ctl_reserved_a: assert property (CTRL_O[3:1] == 3'h0)
        else $error("Reserved control bits not zero");
    rst_pulse_a: assert property (DEV_RESET_O |=> rst_done_s)
        else $error("Device reset not a self-clearing pulse");
    brk_halt_a: assert property (brk_s |-> ##2 CPU_HALT_O)
        else $error("Enabled breakpoint did not halt");
    brk_nop_a: assert property (BRK_DECODE_I && !CTRL_O[6] && !CPU_HALT_O |->
        ##2 !CPU_HALT_O)
        else $error("Disabled breakpoint halted");
    prot_halt_a: assert property (READ_PROTECT_I && CPU_HALT_O && !DEV_RESET_O |=>
        CPU_HALT_O)
        else $error("Halt cleared under read protection");
    req_halted_a: assert property (REQ_O |-> CPU_HALT_O)
        else $error("Request issued while running");
    req_prot_a: assert property (REQ_O && READ_PROTECT_I |->
        REQ_KIND_O == 4'h3 && REQ_ADDR_O >= 16'h0ff8 && REQ_ADDR_O <= 16'h0fff)
        else $error("Protected request outside flash control");
    erase_only_a: assert property (REQ_O && READ_PROTECT_I && REQ_ADDR_O == 16'h0ff8 |->
        REQ_DATA_O == `DCC_MASS_ERASE)
        else $error("Protected flash control write not mass erase");
endmodule
bind dcc_top dcc_top_sva u_sva (.MCLK_I, .RST_N_I, .READ_PROTECT_I, .BRK_DECODE_I, .CPU_HALT_O,
    .BRK_AS_NOP_O, .BRK_LOOP_O, .DEV_RESET_O, .CTRL_O, .REQ_O, .REQ_KIND_O, .REQ_ADDR_O,
    .REQ_DATA_O);
`default_nettype wire

// [tb/dcc_host.sv]
`include "dcc_defs.vh"
`default_nettype none
module dcc_host (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Serial host
    // ****************
    localparam int BIT = `DCC_BAUD_DIV + 1;
    logic [7:0] rxq[$];
    initial line_o = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (BIT - 1) @(posedge clk_i);
        end
    endtask
    task automatic get(output logic [7:0] b);
        int n;
        n = 0;
        while (rxq.size() == 0 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        b = (rxq.size() != 0) ? rxq.pop_front() : 8'hxx;
    endtask
    initial begin : rxp
        logic [7:0] b;
        forever begin
            @(negedge line_i);
            repeat (BIT + BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                b[i] = line_i;
                repeat (BIT) @(posedge clk_i);
            end
            rxq.push_back(b);
        end
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`include "dcc_defs.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Bench
    // ****************
    logic mclk, rst_n, rx_line, tx_line, halt, nop, loop, devrst, req;
    logic prot = 1'b0;
    logic breakpoint_opcode = 1'b0;
    logic cpu_rdy = 1'b0;
    logic [7:0] ctrl, data, ld;
    logic [3:0] kind, lk;
    logic [15:0] addr, la, v, rh, rl;
    logic [7:0] status = 8'h5a;
    logic [7:0] rdd = 8'h77;
    logic [15:0] pc = 16'h1234;
    logic [15:0] crc = 16'hbeef;
    int failures = 0;
    int compares = 0;
    int reqn = 0;
    int rstn = 0;
    dcc_top DUT (.MCLK_I(mclk), .RST_N_I(rst_n), .DBG_RX_I(rx_line), .DBG_TX_O(tx_line),
        .READ_PROTECT_I(prot), .BRK_DECODE_I(breakpoint_opcode), .STATUS_I(status), .PC_I(pc),
        .RD_DATA_I(rdd), .CPU_READY_I(cpu_rdy), .CRC_I(crc), .CPU_HALT_O(halt),
        .BRK_AS_NOP_O(nop), .BRK_LOOP_O(loop), .DEV_RESET_O(devrst), .CTRL_O(ctrl),
        .REQ_O(req), .REQ_KIND_O(kind), .REQ_ADDR_O(addr), .REQ_DATA_O(data));
    dcc_host host (.clk_i(mclk), .line_i(tx_line), .line_o(rx_line));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cpu_rdy <= req;
        if (req === 1'b1) begin
            reqn++;
            lk = kind;
            la = addr;
            ld = data;
        end
        if (devrst === 1'b1) rstn++;
    end
    task automatic print_verdict();
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wctl(input logic [7:0] b);
        host.send(8'h04);
        host.send(b);
        cyc(4);
    endtask
    task automatic rdn(input int n, output logic [15:0] r);
        logic [7:0] b;
        r = 16'h0000;
        for (int i = 0; i < n; i++) begin
            host.get(b);
            r = {r[7:0], b};
        end
    endtask
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (100) begin
            @(posedge mclk);
            if (tx_line !== 1'b1) seen = 1'b1;
        end
        cmp(16'(seen), 16'h0000);
    endtask
    task automatic pulse_brk();
        @(posedge mclk);
        breakpoint_opcode <= 1'b1;
        @(posedge mclk);
        breakpoint_opcode <= 1'b0;
        cyc(3);
    endtask
    task automatic req_check(input int n, input logic [3:0] k);
        cyc(4);
        cmp(16'(reqn), 16'(n));
        if (n > 0) cmp(16'(lk), 16'(k));
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        cmp(16'(ctrl), 16'h0000);
        cmp(16'(nop), 16'h0001);
        pulse_brk();
        cmp(16'(halt), 16'h0000);
    endtask
    task automatic t_reads();
        host.send(`DCC_CMD_REV);
        rdn(2, v);
        cmp(v, `DCC_REVISION);
        host.send(`DCC_CMD_STAT);
        rdn(1, v);
        cmp(v, 16'h005a);
        @(posedge mclk);
        status <= 8'hc3;
        host.send(`DCC_CMD_STAT);
        rdn(1, v);
        cmp(v, 16'h00c3);
    endtask
    task automatic t_running();
        host.send(`DCC_CMD_RPC);
        quiet();
        host.send(`DCC_CMD_STEP);
        req_check(0, 4'h0);
        host.send(`DCC_CMD_RTC);
        quiet();
    endtask
    task automatic t_ctl();
        wctl(8'hfe);
        cmp(16'(ctrl), 16'h00f0);
        cmp(16'({halt, nop, loop}), 16'h0005);
        host.send(`DCC_CMD_RCTL);
        rdn(1, v);
        cmp(v, 16'h00f0);
        wctl(8'h00);
        cmp(16'(halt), 16'h0000);
    endtask
    task automatic t_stop();
        wctl(8'h81);
        cmp(16'(rstn), 16'h0001);
        cmp(16'(ctrl), 16'h0080);
    endtask
    task automatic t_halted();
        host.send(`DCC_CMD_RPC);
        rdn(2, v);
        cmp(v, 16'h1234);
        host.send(8'h0f);
        quiet();
        host.send(`DCC_CMD_STEP);
        req_check(1, 4'h9);
        host.send(`DCC_CMD_STUFF);
        host.send(8'ha5);
        req_check(2, 4'ha);
        cmp(16'(ld), 16'h00a5);
        host.send(`DCC_CMD_EXEC);
        host.send(8'h3c);
        req_check(3, 4'hb);
        host.send(`DCC_CMD_RREG);
        host.send(8'h01);
        host.send(8'h23);
        rdn(1, v);
        cmp(v, 16'h0077);
        req_check(4, 4'h4);
        cmp(la, 16'h0123);
        host.send(`DCC_CMD_RTC);
        rdn(2, rh);
        rdn(2, rl);
        cmp(16'(rh != 16'h0000 || rl != 16'h0000), 16'h0001);
        host.send(`DCC_CMD_RTC);
        rdn(2, v);
        cmp(v, rh);
        rdn(2, v);
        cmp(v, rl);
    endtask
    task automatic t_protect();
        @(posedge mclk);
        prot <= 1'b1;
        host.send(`DCC_CMD_RPC);
        quiet();
        host.send(`DCC_CMD_RPM);
        host.send(8'h01);
        host.send(8'h20);
        quiet();
        req_check(4, 4'h4);
        host.send(`DCC_CMD_WREG);
        host.send(8'h0f);
        host.send(8'hf8);
        host.send(`DCC_MASS_ERASE);
        req_check(5, 4'h3);
        cmp(la, 16'h0ff8);
        cmp(16'(ld), 16'h0063);
        host.send(`DCC_CMD_WREG);
        host.send(8'h01);
        host.send(8'h00);
        host.send(8'h55);
        req_check(5, 4'h3);
        host.send(`DCC_CMD_WREG);
        host.send(8'h1f);
        host.send(8'hf8);
        host.send(`DCC_MASS_ERASE);
        req_check(5, 4'h3);
        host.send(`DCC_CMD_WREG);
        host.send(8'h0f);
        host.send(8'hf8);
        host.send(8'h12);
        req_check(5, 4'h3);
        host.send(`DCC_CMD_CRC);
        rdn(2, v);
        cmp(v, 16'hbeef);
        wctl(8'h00);
        cmp(16'(halt), 16'h0001);
        @(posedge mclk);
        prot <= 1'b0;
    endtask
    task automatic t_run();
        wctl(8'h40);
        cmp(16'(ctrl), 16'h0040);
        pulse_brk();
        cmp(16'(halt), 16'h0001);
        quiet();
        wctl(8'h41);
        cmp(16'(rstn), 16'h0002);
        cmp(16'(ctrl), 16'h0040);
        wctl(8'h60);
        pulse_brk();
        rdn(1, v);
        cmp(v, 16'(`DCC_ACK_BYTE));
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        cyc(4);
        t_reset();
        t_reads();
        t_running();
        t_ctl();
        t_stop();
        t_halted();
        t_protect();
        t_run();
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
